// ---- rtl/peripheral_clock_gating.sv ----
/*
 Peripheral clock gating for the second unit group: run, sleep and
 deep-sleep gating registers on an AHB-Lite slave, power-mode selection,
 per-unit clock enables and bus-fault answers for gated units.
 Assumes power-mode requests and unit accesses come from logic on hclk,
 so no synchroniser stands on them, and that the bus has this one slave,
 with hready fed back from hreadyout. Faults to gated units are reported
 on unit_answer; the register bus itself always answers OKAY.
 Limitation: the unit map is fixed; only thirteen units elaborate.

// Summary of operation
// R1: Each enable bit drives exactly one unit's clock enable; one clocks it.
// R2: Access to a unit whose clock is off is answered with a fault.
// R3: All gating bits are zero after reset, so every unit starts unclocked.
// R4: Run register applies when running, sleep in sleep, deep-sleep in deep sleep.
// R5: Sleep registers only apply when the auto clock gating bit is set.
// R6: Bits 19 to 16 gate timers 3 to 0, read/write.
// R7: Bits 25 and 24 gate comparators 1 and 0, read/write.
// R8: Bits 14 and 12 gate two-wire units 1 and 0, read/write.
// R9: Bits 5 and 4 gate synchronous serial units 1 and 0.
// R10: Bits 2, 1 and 0 gate asynchronous serial units 2, 1, 0.
// R11: Reserved bits are read-only and read as zero.
// R12: Software uses read-modify-write and ignores reserved bit contents.
// R13: A run-mode register with the same layout sits at offset 0x104.
*/
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/1ns
module peripheral_clock_gating
   import clock_gate_pkg::*;
#(
   parameter int NUM_UNITS = UNIT_COUNT
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic sleep_request,
   input wire logic deep_sleep_request,
   input clock_gate_pkg::unit_access_type unit_access,
   output clock_gate_pkg::unit_answer_type unit_answer,
   output logic [NUM_UNITS-1:0] unit_clock_enable,
   output clock_gate_pkg::power_mode_type power_mode
);

   ////////////////////////////////////////////////////////////////////////////
   // Elaboration checks: the bit map is fixed to the thirteen-unit set, the
   // unit index must reach every unit, and every mapped bit must be writable
   genvar gc;
   generate
      if (NUM_UNITS != UNIT_COUNT) begin : g_bad_units
         $error("NUM_UNITS must match the fixed unit count");
      end
      if (NUM_UNITS > (1 << UNIT_INDEX_BITS)) begin : g_bad_index
         $error("NUM_UNITS does not fit the unit index field");
      end
      for (gc = 0; gc < UNIT_COUNT; gc++) begin : g_map_check
         if (GATE_WRITABLE_MASK[UNIT_BIT[gc]] == 1'b0) begin : g_bad_bit
            $error("unit bit map disagrees with the writable mask");
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Power mode; deep sleep wins when both requests stand
   // Requests share hclk, so they are registered here without a synchroniser
   // Entering a mode takes one edge; the unit enables follow one edge later
   power_mode_type mode_d;
   power_mode_type mode_q;

   always_comb begin
      mode_d = mode_q;
      case (mode_q)
         mode_run: begin
            if (deep_sleep_request) begin
               mode_d = mode_deep_sleep;
            end else if (sleep_request) begin
               mode_d = mode_sleep;
            end
         end
         mode_sleep: begin
            if (deep_sleep_request) begin
               mode_d = mode_deep_sleep;
            end else if (!sleep_request) begin
               mode_d = mode_run;
            end
         end
         mode_deep_sleep: begin
            if (!deep_sleep_request) begin
               mode_d = sleep_request ? mode_sleep : mode_run;
            end
         end
         default: begin
            mode_d = mode_run;
         end
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_q <= mode_run;
      end else begin
         mode_q <= mode_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AHB-Lite address phase capture; writes complete in the data phase
   reg_access_type access_d;
   reg_access_type access_q;
   logic addr_phase;

   always_comb begin
      addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ);
      access_d.valid = addr_phase;
      access_d.write = hwrite;
      access_d.offset = haddr[DECODE_BITS-1:0];
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         access_q <= '0;
      end else begin
         access_q <= access_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Write strobes per register
   // Writes land at the end of the data phase, while hwdata stands
   logic data_write;
   logic run_gate_we;
   logic sleep_gate_we;
   logic deep_gate_we;
   logic run_cfg_we;

   always_comb begin
      data_write = access_q.valid && access_q.write;
      run_gate_we = data_write && (access_q.offset == RUN_GATE_OFFSET); // R13
      sleep_gate_we = data_write && (access_q.offset == SLEEP_GATE_OFFSET);
      deep_gate_we = data_write && (access_q.offset == DEEP_SLEEP_GATE_OFFSET);
      run_cfg_we = data_write && (access_q.offset == RUN_CFG_OFFSET);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers; the mask holds reserved bits at zero, reset clears all
   logic [31:0] run_gate_d;
   logic [31:0] run_gate_q;
   logic [31:0] sleep_gate_d;
   logic [31:0] sleep_gate_q;
   logic [31:0] deep_gate_d;
   logic [31:0] deep_gate_q;
   logic [31:0] run_cfg_d;
   logic [31:0] run_cfg_q;

   gate_register #(
      .WRITABLE_MASK(GATE_WRITABLE_MASK),
      .RESET_VALUE(GATE_RESET)
   ) u_run_peripheral_clock_gate (
      .hclk(hclk),
      .hresetn(hresetn),
      .write_enable(run_gate_we),
      .write_data(hwdata),
      .value_d(run_gate_d),
      .value_q(run_gate_q)
   );

   gate_register #(
      .WRITABLE_MASK(GATE_WRITABLE_MASK),
      .RESET_VALUE(GATE_RESET)
   ) u_sleep_peripheral_clock_gate (
      .hclk(hclk),
      .hresetn(hresetn),
      .write_enable(sleep_gate_we),
      .write_data(hwdata),
      .value_d(sleep_gate_d),
      .value_q(sleep_gate_q)
   );

   gate_register #(
      .WRITABLE_MASK(GATE_WRITABLE_MASK),
      .RESET_VALUE(GATE_RESET)
   ) u_deep_sleep_peripheral_clock_gate (
      .hclk(hclk),
      .hresetn(hresetn),
      .write_enable(deep_gate_we),
      .write_data(hwdata),
      .value_d(deep_gate_d),
      .value_q(deep_gate_q)
   );

   gate_register #(
      .WRITABLE_MASK(RUN_CFG_WRITABLE_MASK),
      .RESET_VALUE(RUN_CFG_RESET)
   ) u_run_clock_configuration (
      .hclk(hclk),
      .hresetn(hresetn),
      .write_enable(run_cfg_we),
      .write_data(hwdata),
      .value_d(run_cfg_d),
      .value_q(run_cfg_q)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Read selects, decoded in the address phase; the write strobes decode in the data phase
   logic read_phase;
   logic run_gate_re;
   logic sleep_gate_re;
   logic deep_gate_re;
   logic run_cfg_re;

   always_comb begin
      read_phase = addr_phase && !hwrite;
      run_gate_re = read_phase && (access_d.offset == RUN_GATE_OFFSET); // R13
      sleep_gate_re = read_phase && (access_d.offset == SLEEP_GATE_OFFSET);
      deep_gate_re = read_phase && (access_d.offset == DEEP_SLEEP_GATE_OFFSET);
      run_cfg_re = read_phase && (access_d.offset == RUN_CFG_OFFSET);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data, taken from next values so a read right after a write
   // sees the new contents; unmapped offsets read zero with OKAY
   logic [31:0] rdata_d;
   logic [31:0] rdata_q;

   always_comb begin
      rdata_d = rdata_q;
      if (read_phase) begin
         rdata_d = '0; // R11
      end
      if (run_gate_re) begin
         rdata_d = run_gate_d;
      end
      if (sleep_gate_re) begin
         rdata_d = sleep_gate_d;
      end
      if (deep_gate_re) begin
         rdata_d = deep_gate_d;
      end
      if (run_cfg_re) begin
         rdata_d = run_cfg_d;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Zero-wait-state slave: every register answers in one data phase, and a
   // fault to a gated unit travels on unit_answer, so the bus never stalls
   logic ready_d;
   logic ready_q;
   logic resp_d;
   logic resp_q;

   always_comb begin
      ready_d = 1'b1;
      resp_d = HRESP_OKAY;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ready_q <= 1'b1;
         resp_q <= HRESP_OKAY;
      end else begin
         ready_q <= ready_d;
         resp_q <= resp_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register chosen by power mode; without auto gating the run set stays
   logic [31:0] active_gate;
   logic auto_gating;
   logic [31:0] sleep_set;
   logic [31:0] deep_set;

   always_comb begin
      auto_gating = run_cfg_q[AUTO_CLOCK_GATING_ENABLE_BIT];
      sleep_set = auto_gating ? sleep_gate_q : run_gate_q; // R5
      deep_set = auto_gating ? deep_gate_q : run_gate_q; // R5
      case (mode_q)
         mode_run: active_gate = run_gate_q; // R4
         mode_sleep: active_gate = sleep_set; // R4
         mode_deep_sleep: active_gate = deep_set; // R4
         default: active_gate = run_gate_q;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // One enable per unit from its own bit; one cycle of latency traded
   // for glitch-free flop outputs into the clock gates
   logic [NUM_UNITS-1:0] enable_d;
   logic [NUM_UNITS-1:0] enable_q;

   genvar gi;
   generate
      for (gi = 0; gi < NUM_UNITS; gi++) begin : g_unit
         assign enable_d[gi] = active_gate[UNIT_BIT[gi]]; // R1 R6 R7 R8 R9 R10
      end
   endgenerate

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         enable_q <= '0; // R3
      end else begin
         enable_q <= enable_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Fault answers for accesses to units judged against live enables
   // Registered enables are used, the very clock each unit sees this cycle
   unit_access_guard #(
      .NUM_UNITS(NUM_UNITS)
   ) u_guard (
      .hclk(hclk),
      .hresetn(hresetn),
      .unit_access(unit_access),
      .unit_enable(enable_q),
      .unit_answer(unit_answer)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   // Every output is a flop; the unit clock gates must see no glitches
   assign hreadyout = ready_q;
   assign hresp = resp_q;
   assign hrdata = rdata_q;
   assign unit_clock_enable = enable_q;
   assign power_mode = mode_q;

endmodule : peripheral_clock_gating

// ---- rtl/clock_gate_pkg.sv ----
/*
 Constants, field layouts and carrier types for the low-power peripheral
 clock gating block. Assumes one system clock domain and a 4 KB decode window.
*/
package clock_gate_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register map (byte offsets inside the system control window)
   localparam int DECODE_BITS = 12;
   localparam logic [DECODE_BITS-1:0] RUN_GATE_OFFSET = 12'h104;
   localparam logic [DECODE_BITS-1:0] SLEEP_GATE_OFFSET = 12'h114;
   localparam logic [DECODE_BITS-1:0] DEEP_SLEEP_GATE_OFFSET = 12'h124;
   localparam logic [DECODE_BITS-1:0] RUN_CFG_OFFSET = 12'h1f0;

   ////////////////////////////////////////////////////////////////////////////
   // Field layout of the three gating registers and the run configuration register
   localparam logic [31:0] GATE_WRITABLE_MASK = 32'h030f_5037;
   localparam logic [31:0] GATE_RESET = 32'h0000_0000;
   localparam logic [31:0] RUN_CFG_WRITABLE_MASK = 32'h0000_0001;
   localparam logic [31:0] RUN_CFG_RESET = 32'h0000_0000;
   localparam int AUTO_CLOCK_GATING_ENABLE_BIT = 0;

   localparam int ASYNC_SERIAL_UNIT_ZERO_GATE_BIT = 'h0;
   localparam int ASYNC_SERIAL_UNIT_ONE_GATE_BIT = 'h1;
   localparam int ASYNC_SERIAL_UNIT_TWO_GATE_BIT = 'h2;
   localparam int SYNC_SERIAL_UNIT_ZERO_GATE_BIT = 'h4;
   localparam int SYNC_SERIAL_UNIT_ONE_GATE_BIT = 'h5;
   localparam int TWO_WIRE_UNIT_ZERO_GATE_BIT = 'hc;
   localparam int TWO_WIRE_UNIT_ONE_GATE_BIT = 'he;
   localparam int GP_TIMER_ZERO_GATE_BIT = 'h10;
   localparam int GP_TIMER_ONE_GATE_BIT = 'h11;
   localparam int GP_TIMER_TWO_GATE_BIT = 'h12;
   localparam int GP_TIMER_THREE_GATE_BIT = 'h13;
   localparam int COMPARATOR_ZERO_GATE_BIT = 'h18;
   localparam int COMPARATOR_ONE_GATE_BIT = 'h19;

   localparam int UNIT_COUNT = 13;
   localparam int UNIT_INDEX_BITS = 4;

   // Unit index to register bit position
   localparam int UNIT_BIT [UNIT_COUNT] = '{
      ASYNC_SERIAL_UNIT_ZERO_GATE_BIT, ASYNC_SERIAL_UNIT_ONE_GATE_BIT,
      ASYNC_SERIAL_UNIT_TWO_GATE_BIT, SYNC_SERIAL_UNIT_ZERO_GATE_BIT,
      SYNC_SERIAL_UNIT_ONE_GATE_BIT, TWO_WIRE_UNIT_ZERO_GATE_BIT,
      TWO_WIRE_UNIT_ONE_GATE_BIT, GP_TIMER_ZERO_GATE_BIT,
      GP_TIMER_ONE_GATE_BIT, GP_TIMER_TWO_GATE_BIT,
      GP_TIMER_THREE_GATE_BIT, COMPARATOR_ZERO_GATE_BIT,
      COMPARATOR_ONE_GATE_BIT};

   ////////////////////////////////////////////////////////////////////////////
   // Bus encodings
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic HRESP_OKAY = 1'h0;

   ////////////////////////////////////////////////////////////////////////////
   // Types
   typedef enum logic [1:0] {mode_run, mode_sleep, mode_deep_sleep} power_mode_type;

   typedef struct packed {
      logic valid;
      logic write;
      logic [DECODE_BITS-1:0] offset;
   } reg_access_type;

   typedef struct packed {
      logic valid;
      logic [UNIT_INDEX_BITS-1:0] unit;
   } unit_access_type;

   typedef struct packed {
      logic done;
      logic fault;
   } unit_answer_type;

endpackage : clock_gate_pkg

// ---- rtl/gate_register.sv ----
/*
 One 32-bit software register whose writable bits are set by a mask.
 Assumes the caller forms the write strobe; reserved bits stay at zero.
*/
`timescale 1ns/1ns
module gate_register #(
   parameter logic [31:0] WRITABLE_MASK = 32'hffff_ffff,
   parameter logic [31:0] RESET_VALUE = 32'h0000_0000
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic write_enable,
   input wire logic [31:0] write_data,
   output logic [31:0] value_d,
   output logic [31:0] value_q
);

   ////////////////////////////////////////////////////////////////////////////
   // Masking on write keeps reserved positions at zero for every read
   always_comb begin
      value_d = value_q;
      if (write_enable) begin
         value_d = write_data & WRITABLE_MASK;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         value_q <= RESET_VALUE & WRITABLE_MASK;
      end else begin
         value_q <= value_d;
      end
   end

endmodule : gate_register

// ---- rtl/unit_access_guard.sv ----
/*
 Answers each access aimed at a controlled unit: fault when its clock is off.
 Assumes requests and enables come from logic on hclk.
*/
`timescale 1ns/1ns
module unit_access_guard
   import clock_gate_pkg::*;
#(
   parameter int NUM_UNITS = UNIT_COUNT
) (
   input wire logic hclk,
   input wire logic hresetn,
   input clock_gate_pkg::unit_access_type unit_access,
   input wire logic [NUM_UNITS-1:0] unit_enable,
   output clock_gate_pkg::unit_answer_type unit_answer
);

   unit_answer_type answer_d;
   logic in_range;

   ////////////////////////////////////////////////////////////////////////////
   // Elaboration check: the unit index field must reach every unit
   generate
      if (NUM_UNITS > (1 << UNIT_INDEX_BITS)) begin : g_bad_index
         $error("NUM_UNITS does not fit the unit index field");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Indices beyond the controlled set are not ours and complete normally
   always_comb begin
      in_range = 32'(unit_access.unit) < NUM_UNITS;
      answer_d.done = unit_access.valid;
      answer_d.fault = 1'b0;
      if (unit_access.valid && in_range) begin
         answer_d.fault = !unit_enable[unit_access.unit]; // R2
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         unit_answer <= '0;
      end else begin
         unit_answer <= answer_d;
      end
   end

endmodule : unit_access_guard

// ---- bench/gating_props.sv ----
/*
 Port checker for the peripheral clock gating block, bound to its top.
 Assumes one hclk domain and hresetn active low.
*/
`timescale 1ns/1ns
module gating_props
   import clock_gate_pkg::*;
#(
   parameter int NUM_UNITS = UNIT_COUNT
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic sleep_request,
   input wire logic deep_sleep_request,
   input clock_gate_pkg::unit_access_type unit_access,
   input clock_gate_pkg::unit_answer_type unit_answer,
   input wire logic [NUM_UNITS-1:0] unit_clock_enable,
   input clock_gate_pkg::power_mode_type power_mode
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   logic wr_taken;
   assign wr_taken = hsel && hready && htrans == HTRANS_NONSEQ && hwrite;

   ////////////////////////////////////////////////////////////////////////////
   // Unit accesses split by the clock state of the addressed unit
   sequence s_gated;
      unit_access.valid && unit_access.unit < NUM_UNITS && !unit_clock_enable[unit_access.unit];
   endsequence
   sequence s_clocked;
      unit_access.valid && (unit_access.unit >= NUM_UNITS || unit_clock_enable[unit_access.unit]);
   endsequence

   a_bus_ready_okay: assert property (hreadyout && hresp == HRESP_OKAY)
      else $error("bus slave stalled or answered other than OKAY");
   a_answer_done: assert property (unit_access.valid |=> unit_answer.done)
      else $error("unit access got no answer one cycle later");
   a_done_only_asked: assert property (!unit_access.valid |=> !unit_answer.done)
      else $error("unit answer without an access");
   a_gated_fault: assert property (s_gated |=> unit_answer.fault)
      else $error("access to an unclocked unit completed without fault");
   a_clocked_pass: assert property (s_clocked |=> !unit_answer.fault)
      else $error("access to a clocked unit faulted");
   a_deep_wins: assert property (deep_sleep_request |=> power_mode == mode_deep_sleep)
      else $error("deep sleep request not taken");
   a_sleep_mode: assert property (sleep_request && !deep_sleep_request |=>
      power_mode == mode_sleep)
      else $error("sleep request not taken");
   a_run_mode: assert property (!sleep_request && !deep_sleep_request |=>
      power_mode == mode_run)
      else $error("run mode not restored");
   // Enables move only two edges after a write is accepted or one edge after a mode change
   a_enable_cause: assert property ($changed(unit_clock_enable) |->
      $past(wr_taken, 3) || $past(power_mode) != $past(power_mode, 2))
      else $error("unit enables changed without cause");
endmodule : gating_props

bind peripheral_clock_gating gating_props #(.NUM_UNITS(NUM_UNITS)) gating_props_inst (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sleep_request(sleep_request),
   .deep_sleep_request(deep_sleep_request), .unit_access(unit_access),
   .unit_answer(unit_answer), .unit_clock_enable(unit_clock_enable),
   .power_mode(power_mode));

// ---- bench/peripheral_clock_gating_bench.sv ----
/*
 Self-checking bench for the peripheral clock gating block.
 Assumes the design package is compiled first; the bench is the bus master.
*/
`timescale 1ns/1ns
module peripheral_clock_gating_bench;
   import clock_gate_pkg::*;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hready;
   logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
   logic [1:0] htrans = '0;
   logic [2:0] hsize = 3'h2;
   logic sleep_request = 0, deep_sleep_request = 0, hreadyout, hresp;
   unit_access_type unit_access = '0;
   unit_answer_type unit_answer;
   logic [UNIT_COUNT-1:0] unit_clock_enable;
   power_mode_type power_mode;
   int n_mismatch = 0, checks = 0;
   // Register bit of each unit, in unit index order
   int bit_of [13] = '{0, 1, 2, 4, 5, 12, 14, 16, 17, 18, 19, 24, 25};
   logic [11:0] offs [3] = '{RUN_GATE_OFFSET, SLEEP_GATE_OFFSET, DEEP_SLEEP_GATE_OFFSET};

   assign hready = hreadyout;
   initial begin
      forever #50 hclk = ~hclk;
   end

   peripheral_clock_gating peripheral_clock_gating_inst (.hclk, .hresetn, .hsel, .haddr,
      .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hresp, .hrdata,
      .sleep_request, .deep_sleep_request, .unit_access, .unit_answer,
      .unit_clock_enable, .power_mode);

   ////////////////////////////////////////////////////////////////////////////
   task automatic wrap_up;
      $display("mismatches %0d checks %0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : wrap_up

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask : check

   // A hung slave ends the run rather than the wait
   task automatic wait_ready;
      int n;
      n = 0;
      @(posedge hclk);
      while (hready !== 1'b1) begin
         n++;
         if (n > 20) begin
            n_mismatch++;
            $display("unexpected at %0t: bus never ready", $time);
            wrap_up;
         end
         @(posedge hclk);
      end
   endtask : wait_ready

   task automatic bus(input logic wr, input logic [11:0] off, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {20'h0, off};
      hwrite <= wr;
      htrans <= HTRANS_NONSEQ;
      wait_ready;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      wait_ready;
      rd = hrdata;
   endtask : bus

   task automatic read_expect(input logic [11:0] off, input logic [31:0] exp);
      bus(1'b0, off, 32'h0);
      check(rd, exp, "register read");
   endtask : read_expect

   task automatic poke(input int u, input logic f);
      @(posedge hclk);
      unit_access <= '{1'b1, 4'(u)};
      @(posedge hclk);
      unit_access <= '0;
      #1;
      check(32'(unit_answer), {30'h0, 1'b1, f}, "unit answer");
   endtask : poke

   task automatic mode(input logic s, input logic d, input logic [12:0] e);
      @(posedge hclk);
      sleep_request <= s;
      deep_sleep_request <= d;
      repeat (2) @(posedge hclk);
      #1;
      check(32'(unit_clock_enable), 32'(e), "mode enables");
   endtask : mode

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      #1;
      check(32'(unit_clock_enable), 32'h0, "reset enables");
      check(32'(power_mode), 32'(mode_run), "reset mode");
      for (int r = 0; r < 3; r++) read_expect(offs[r], 32'h0);
      read_expect(RUN_CFG_OFFSET, 32'h0);
   endtask : t_reset

   task automatic t_fields;
      logic [31:0] m;
      m = '0;
      for (int i = 0; i < 13; i++) m |= 32'h1 << bit_of[i];
      for (int r = 0; r < 3; r++) begin
         bus(1'b1, offs[r], 32'hffff_ffff);
         read_expect(offs[r], m);
         bus(1'b1, offs[r], 32'h0);
         read_expect(offs[r], 32'h0);
      end
      for (int i = 0; i < 13; i++) begin
         bus(1'b1, RUN_GATE_OFFSET, 32'h1 << bit_of[i]);
         @(posedge hclk);
         #1;
         check(32'(unit_clock_enable), 32'h1 << i, "unit enable");
         poke(i, 1'b0);
         poke((i + 1) % 13, 1'b1);
      end
      poke(13, 1'b0);
      bus(1'b1, 12'h200, 32'hffff_ffff);
      read_expect(12'h200, 32'h0);
      // Software keeps what it read and adds one timer
      bus(1'b0, RUN_GATE_OFFSET, 32'h0);
      bus(1'b1, RUN_GATE_OFFSET, rd | 32'h0001_0000);
      read_expect(RUN_GATE_OFFSET, 32'h0201_0000);
   endtask : t_fields

   task automatic t_modes;
      bus(1'b1, RUN_GATE_OFFSET, 32'h0000_0001);
      bus(1'b1, SLEEP_GATE_OFFSET, 32'h0000_1000);
      bus(1'b1, DEEP_SLEEP_GATE_OFFSET, 32'h0200_0000);
      mode(1'b1, 1'b0, 13'h0001);
      mode(1'b0, 1'b1, 13'h0001);
      mode(1'b0, 1'b0, 13'h0001);
      bus(1'b1, RUN_CFG_OFFSET, 32'hffff_ffff);
      read_expect(RUN_CFG_OFFSET, 32'h0000_0001);
      mode(1'b1, 1'b0, 13'h0020);
      poke(0, 1'b1);
      mode(1'b1, 1'b1, 13'h1000);
      poke(12, 1'b0);
      mode(1'b0, 1'b0, 13'h0001);
   endtask : t_modes

   initial begin
      t_reset;
      t_fields;
      t_modes;
      t_reset;
      wrap_up;
   end
endmodule : peripheral_clock_gating_bench
